// ---- rtl/fsp_sequencer.sv ----
/*
  Flash self-program sequencer: arms commands written over classic
  Wishbone, executes them on store/load program strobes from the core,
  holds the temporary page buffer, lock bits and fuse readback.
  Assumes the core strobes, the eeprom status and the buffer read index
  come from logic on ref_clk; the flash array itself lies outside.
*/
// The address map and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps

module fsp_sequencer
  import fsp_pkg::*;
#(
  parameter int PROG_CYCLES = FSP_PROG_CYCLES
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire fsp_instr_type instr,
  input wire logic eeprom_write_active,
  input wire logic eeprom_write_start,
  input wire logic [FSP_WIDX_W-1:0] buf_rd_idx,
  output logic [15:0] buf_rd_data,
  output logic [7:0] lpm_data,
  output logic lpm_valid,
  output fsp_flash_op_type flash_op,
  output logic region_busy_flag,
  output logic cpu_halt,
  output logic ready_irq
);

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  function automatic logic is_valid_cmd(input logic [4:0] c);
    is_valid_cmd = (c == FSP_CMD_LOAD) || (c == FSP_CMD_ERASE) || (c == FSP_CMD_WRITE) ||
                   (c == FSP_CMD_LOCK) || (c == FSP_CMD_REEN);
  endfunction : is_valid_cmd

  function automatic logic is_prog_cmd(input logic [4:0] c);
    is_prog_cmd = (c == FSP_CMD_ERASE) || (c == FSP_CMD_WRITE) || (c == FSP_CMD_LOCK);
  endfunction : is_prog_cmd

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  fsp_state_type state;
  logic [4:0] cmd;
  logic [4:0] op_cmd;
  logic [2:0] spm_win;
  logic [2:0] lpm_win;
  logic [FSP_CNT_W-1:0] prog_cnt;
  logic [FSP_PAGE_W-1:0] op_page;
  logic [5:0] op_data;
  logic ready_irq_enable;
  logic [5:0] lock_bits;
  logic buf_loaded;
  logic [15:0] buf_mem [FSP_PAGE_WORDS];

  logic bus_wr;
  logic ctrl_wr;
  logic arm_ok;
  logic spm_take;
  logic lpm_take;
  logic start_op;
  logic op_done;
  logic load_take;
  logic reen_take;
  logic buf_clear;
  logic [FSP_PAGE_W-1:0] z_page;
  logic [FSP_WIDX_W-1:0] z_widx;

  assign z_page = instr.ptr[FSP_PAGE_LSB +: FSP_PAGE_W];
  assign z_widx = instr.ptr[FSP_WIDX_LSB +: FSP_WIDX_W];
  assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
  assign ctrl_wr = bus_wr && (wb_adr_i == FSP_CTRL_OFS);
  assign arm_ok = ctrl_wr && is_valid_cmd(wb_dat_i[4:0]) && !eeprom_write_active &&
                  (state != FSP_PROG);
  assign spm_take = (state == FSP_ARMED) && instr.spm && !eeprom_write_active && !arm_ok;
  assign lpm_take = (state == FSP_ARMED) && instr.load_program_instr && (cmd == FSP_CMD_LOCK) &&
                    (lpm_win != 3'h0) && !eeprom_write_active && !spm_take && !arm_ok;
  assign start_op = spm_take && is_prog_cmd(cmd);
  assign load_take = spm_take && (cmd == FSP_CMD_LOAD);
  assign reen_take = spm_take && (cmd == FSP_CMD_REEN);
  assign op_done = (state == FSP_PROG) && (prog_cnt == '0);
  assign buf_clear = (op_done && (op_cmd == FSP_CMD_WRITE)) || reen_take ||
                     (eeprom_write_start && buf_loaded);

  // ---------------------------------------------------------------
  // Command sequencer
  // ---------------------------------------------------------------
  // arming window counter
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state <= FSP_IDLE;
      cmd <= FSP_CMD_NONE;
      spm_win <= 3'h0;
      lpm_win <= 3'h0;
    end else begin
      case (state)
        FSP_IDLE: begin
          if (arm_ok) begin
            state <= FSP_ARMED;
            cmd <= wb_dat_i[4:0];
            spm_win <= FSP_SPM_WINDOW;
            lpm_win <= FSP_LPM_WINDOW;
          end
        end
        FSP_ARMED: begin
          if (arm_ok) begin
            cmd <= wb_dat_i[4:0];
            spm_win <= FSP_SPM_WINDOW;
            lpm_win <= FSP_LPM_WINDOW;
          end else if (start_op) begin
            state <= FSP_PROG;
          end else if (spm_take || lpm_take || (spm_win == 3'h1)) begin
            state <= FSP_IDLE;
            cmd <= FSP_CMD_NONE;
          end else begin
            spm_win <= spm_win - 3'h1;
            lpm_win <= (lpm_win == 3'h0) ? 3'h0 : lpm_win - 3'h1;
          end
        end
        FSP_PROG: begin
          if (op_done) begin
            state <= FSP_IDLE;
            cmd <= FSP_CMD_NONE;
          end
        end
        default: begin
          state <= FSP_IDLE;
          cmd <= FSP_CMD_NONE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Programming timer and latched operands
  // ---------------------------------------------------------------
  // calibrated programming time
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prog_cnt <= '0;
      op_cmd <= FSP_CMD_NONE;
      op_page <= '0;
      op_data <= '0;
    end else if (start_op) begin
      prog_cnt <= FSP_CNT_W'(PROG_CYCLES - 1);
      op_cmd <= cmd;
      op_page <= (cmd == FSP_CMD_LOCK) ? '0 : z_page;
      op_data <= instr.data[5:0];
    end else if ((state == FSP_PROG) && (prog_cnt != '0)) begin
      prog_cnt <= prog_cnt - 1'b1;
    end
  end

  // The page is latched at the start, so the pointer is free afterwards.
  // erase, write and lock requests
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      flash_op <= '0;
    end else begin
      flash_op.start <= start_op && (cmd != FSP_CMD_LOCK);
      flash_op.erase <= start_op && (cmd == FSP_CMD_ERASE);
      flash_op.write <= start_op && (cmd == FSP_CMD_WRITE);
      flash_op.lock <= start_op && (cmd == FSP_CMD_LOCK);
      flash_op.page <= start_op ? z_page : flash_op.page;
    end
  end

  // ---------------------------------------------------------------
  // Region busy flag and core halt
  // ---------------------------------------------------------------
  // busy blocks region reads
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      region_busy_flag <= 1'b0;
    end else if (start_op && (cmd != FSP_CMD_LOCK) && (z_page < FSP_NO_CONCURRENT_READ_REGION_FIRST_PAGE)) begin
      region_busy_flag <= 1'b1;
    end else if (load_take || reen_take) begin
      region_busy_flag <= 1'b0;
    end
  end

  // Lock programming leaves the whole array readable, so it never halts.
  // halt for protected region
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cpu_halt <= 1'b0;
    end else if (start_op && (cmd != FSP_CMD_LOCK) && (z_page >= FSP_NO_CONCURRENT_READ_REGION_FIRST_PAGE)) begin
      cpu_halt <= 1'b1;
    end else if (op_done) begin
      cpu_halt <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Temporary page buffer
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < FSP_PAGE_WORDS; gi++) begin : g_buf
      always_ff @(posedge ref_clk) begin
        // A word loaded in the cycle of a discard survives it; the load wins.
        if (srst) begin
          buf_mem[gi] <= FSP_ERASED_WORD;
        end else if (load_take && (z_widx == FSP_WIDX_W'(gi))) begin
          buf_mem[gi] <= instr.data;
        end else if (buf_clear) begin
          buf_mem[gi] <= FSP_ERASED_WORD;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      buf_loaded <= 1'b0;
    end else if (load_take) begin
      buf_loaded <= 1'b1;
    end else if (buf_clear) begin
      buf_loaded <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      buf_rd_data <= FSP_ERASED_WORD;
    end else begin
      buf_rd_data <= buf_mem[buf_rd_idx];
    end
  end

  // ---------------------------------------------------------------
  // Lock bits and readback
  // ---------------------------------------------------------------
  // Locks only move towards programmed; a one in the data never unlocks.
  // zero bits program locks
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      lock_bits <= FSP_LOCK_RESET;
    end else if (op_done && (op_cmd == FSP_CMD_LOCK)) begin
      lock_bits <= {lock_bits[5:2] & op_data[5:2], lock_bits[1:0]};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      lpm_data <= 8'h00;
      lpm_valid <= 1'b0;
    end else begin
      lpm_valid <= lpm_take;
      if (lpm_take) begin
        case (instr.ptr)
          FSP_PTR_FUSE_LOW: lpm_data <= FSP_FUSE_LOW_RESET;
          FSP_PTR_LOCK: lpm_data <= {2'b11, lock_bits};
          FSP_PTR_FUSE_EXT: lpm_data <= {6'h3F, FSP_FUSE_EXT_RESET};
          FSP_PTR_FUSE_HIGH: lpm_data <= FSP_FUSE_HIGH_RESET;
          default: lpm_data <= 8'hFF;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupt enable and ready request
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ready_irq_enable <= 1'b0;
    end else if (ctrl_wr) begin
      ready_irq_enable <= wb_dat_i[FSP_IE_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ready_irq <= 1'b0;
    end else begin
      ready_irq <= ready_irq_enable && (state == FSP_IDLE) && !arm_ok;
    end
  end

  // ---------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------
  // Ack rises one cycle after the request and drops the cycle after,
  // which keeps every access a plain two-edge handshake.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
        case (wb_adr_i)
          FSP_CTRL_OFS: wb_dat_o <= {24'h00_0000, ready_irq_enable, region_busy_flag, 1'b0, cmd};
          FSP_LOCK_OFS: wb_dat_o <= {24'h00_0000, 2'b11, lock_bits};
          FSP_PTR_OFS: wb_dat_o <= {16'h0000, instr.ptr};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule : fsp_sequencer

// ---- common/fsp_pkg.sv ----
/*
  Package of the flash self-program sequencer: register map, command
  patterns, pointer layout, timing constants and carrier types.
  Assumes a 40 MHz system clock and a single clock domain.
*/
package fsp_pkg;

  // ---------------------------------------------------------------
  // Register map (byte offsets on the bus)
  // ---------------------------------------------------------------
  localparam logic [7:0] FSP_CTRL_OFS = 8'h00;
  localparam logic [7:0] FSP_LOCK_OFS = 8'h04;
  localparam logic [7:0] FSP_PTR_OFS = 8'h08;

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int FSP_IE_BIT = 7;
  localparam int FSP_BUSY_BIT = 6;
  localparam logic [4:0] FSP_CMD_LOAD = 5'b0_0001;
  localparam logic [4:0] FSP_CMD_ERASE = 5'b0_0011;
  localparam logic [4:0] FSP_CMD_WRITE = 5'b0_0101;
  localparam logic [4:0] FSP_CMD_LOCK = 5'b0_1001;
  localparam logic [4:0] FSP_CMD_REEN = 5'b1_0001;
  localparam logic [4:0] FSP_CMD_NONE = 5'b0_0000;

  // ---------------------------------------------------------------
  // Pointer layout and page buffer
  // ---------------------------------------------------------------
  localparam int FSP_PAGE_WORDS = 128;
  localparam int FSP_WIDX_W = 7;
  localparam int FSP_WIDX_LSB = 1;
  localparam int FSP_PAGE_LSB = 8;
  localparam int FSP_PAGE_W = 8;
  localparam logic [7:0] FSP_NO_CONCURRENT_READ_REGION_FIRST_PAGE = 8'hE0;
  localparam logic [15:0] FSP_ERASED_WORD = 16'hFFFF;
  localparam logic [15:0] FSP_PTR_FUSE_LOW = 16'h0000;
  localparam logic [15:0] FSP_PTR_LOCK = 16'h0001;
  localparam logic [15:0] FSP_PTR_FUSE_EXT = 16'h0002;
  localparam logic [15:0] FSP_PTR_FUSE_HIGH = 16'h0003;

  // ---------------------------------------------------------------
  // Values after reset (one = unprogrammed)
  // ---------------------------------------------------------------
  localparam logic [5:0] FSP_LOCK_RESET = 6'h3F;
  localparam logic [7:0] FSP_FUSE_LOW_RESET = 8'hFF;
  localparam logic [7:0] FSP_FUSE_HIGH_RESET = 8'hFF;
  localparam logic [1:0] FSP_FUSE_EXT_RESET = 2'h3;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int FSP_CLK_PS = 25_000;
  localparam int FSP_PROG_MIN_US = 3_700;
  localparam int FSP_PROG_MAX_US = 4_500;
  // Worked in nanoseconds so that the intermediate product fits in 32 bits.
  localparam int FSP_PROG_CYCLES =
    (FSP_PROG_MIN_US * 1_000 + FSP_CLK_PS / 1_000 - 1) / (FSP_CLK_PS / 1_000);
  localparam logic [2:0] FSP_SPM_WINDOW = 3'h4;
  localparam logic [2:0] FSP_LPM_WINDOW = 3'h3;
  localparam int FSP_CNT_W = 18;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic spm;
    logic load_program_instr;
    logic [15:0] ptr;
    logic [15:0] data;
  } fsp_instr_type;

  typedef struct packed {
    logic start;
    logic erase;
    logic write;
    logic lock;
    logic [FSP_PAGE_W-1:0] page;
  } fsp_flash_op_type;

  typedef enum logic [1:0] {
    FSP_IDLE,
    FSP_ARMED,
    FSP_PROG
  } fsp_state_type;

endpackage : fsp_pkg

// ---- verif/fsp_sequencer_assertions.sv ----
/*
  Port checker for the flash self-program sequencer.
  Assumes one clock, ref_clk, and a synchronous active-high srst.
*/
`timescale 1ns/1ps
module fsp_sequencer_checker
  import fsp_pkg::*;
#(
  parameter int PROG_CYCLES = 20
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire fsp_instr_type instr,
  input wire logic eeprom_write_active,
  input wire logic lpm_valid,
  input wire fsp_flash_op_type flash_op,
  input wire logic region_busy_flag,
  input wire logic cpu_halt,
  input wire logic ready_irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  int halt_cnt;

  always_ff @(posedge ref_clk) begin
    if (srst || !cpu_halt) begin
      halt_cnt <= 0;
    end else begin
      halt_cnt <= halt_cnt + 1;
    end
  end

  busy_on_rww_a: assert property (
    flash_op.start && flash_op.page < FSP_NO_CONCURRENT_READ_REGION_FIRST_PAGE |-> region_busy_flag && !cpu_halt)
    else $error("rww program without busy flag");
  halt_on_no_concurrent_read_region_a: assert property (
    flash_op.start && flash_op.page >= FSP_NO_CONCURRENT_READ_REGION_FIRST_PAGE |-> cpu_halt)
    else $error("no_concurrent_read_region program without halt");
  halt_length_a: assert property ($fell(cpu_halt) |->
    halt_cnt >= PROG_CYCLES - 1 && halt_cnt <= PROG_CYCLES + 1)
    else $error("programming time off");
  irq_quiet_a: assert property (cpu_halt [*2] |-> !ready_irq)
    else $error("ready interrupt while programming");
  start_pulse_a: assert property (flash_op.start |=> !flash_op.start)
    else $error("start longer than one cycle");
  op_cause_a: assert property (flash_op.start |->
    $past(instr.spm) && (flash_op.erase ^ flash_op.write) && !flash_op.lock)
    else $error("start without store strobe");
  readback_cause_a: assert property (lpm_valid |->
    $past(instr.load_program_instr) && !$past(eeprom_write_active))
    else $error("readback without load strobe");
  eeprom_block_a: assert property (instr.spm && eeprom_write_active |=>
    !(flash_op.start || flash_op.lock))
    else $error("command ran during eeprom write");

  cover property (lpm_valid);
  cover property (flash_op.start && cpu_halt);
  cover property ($rose(ready_irq));
endmodule : fsp_sequencer_checker

bind fsp_sequencer fsp_sequencer_checker #(.PROG_CYCLES(PROG_CYCLES)) chk_u (
  .ref_clk, .srst, .instr, .eeprom_write_active, .lpm_valid,
  .flash_op, .region_busy_flag, .cpu_halt, .ready_irq
);

// ---- verif/fsp_core_model.sv ----
/*
  Behavioural core issuing store and load program strobes.
  Assumes go is raised for one cycle right after the control write lands.
*/
`timescale 1ns/1ps
module fsp_core_model
  import fsp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic go,
  input wire logic go_lpm,
  input wire logic [2:0] go_dly,
  input wire logic [15:0] go_ptr,
  input wire logic [15:0] go_data,
  output fsp_instr_type instr
);
  logic pend;
  logic lpm_q;
  logic [2:0] cnt;
  logic [15:0] ptr_q;
  logic [15:0] data_q;
  logic fire;
  assign fire = go ? go_dly == 3'h0 : pend && cnt == 3'h1;

  always_ff @(posedge ref_clk) begin
    if (go) begin
      cnt <= go_dly;
      lpm_q <= go_lpm;
      ptr_q <= go_ptr;
      data_q <= go_data;
    end else begin
      cnt <= cnt - 3'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pend <= 1'b0;
      instr <= '0;
    end else if (fire) begin
      pend <= 1'b0;
      instr.spm <= go ? !go_lpm : !lpm_q;
      instr.load_program_instr <= go ? go_lpm : lpm_q;
      instr.ptr <= go ? go_ptr : ptr_q;
      instr.data <= go ? go_data : data_q;
    end else begin
      pend <= pend || go;
      instr.spm <= 1'b0;
      instr.load_program_instr <= 1'b0;
      // Idle operands toggle, so a stale value never passes for a driven one.
      instr.ptr <= ~instr.ptr;
      instr.data <= ~instr.data;
    end
  end
endmodule : fsp_core_model

// ---- verif/fsp_sequencer_bench.sv ----
/*
  Self-checking bench of the flash self-program sequencer.
  Assumes fsp_core_model on the instruction port and the bound checker.
*/
`timescale 1ns/1ps
module fsp_sequencer_bench
  import fsp_pkg::*;
();
  localparam int PROG = 20;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  fsp_instr_type instr;
  logic ee_act = 1'b0;
  logic ee_start = 1'b0;
  logic [6:0] idx = 7'h00;
  logic [15:0] bufd;
  logic [7:0] lpm_data;
  logic lpm_valid;
  fsp_flash_op_type flash_op;
  logic busy;
  logic halt;
  logic irq;
  logic go = 1'b0;
  logic go_lpm = 1'b0;
  logic [2:0] go_dly = 3'h0;
  logic [15:0] go_ptr = 16'h0000;
  logic [15:0] go_data = 16'h0000;
  int failures = 0;
  int checked = 0;
  integer seed = 32'h63e7;
  logic [31:0] exp_q[$];
  logic [7:0] bad[4] = '{8'h07, 8'h1F, 8'h13, 8'h02};
  logic [7:0] fuse[4] = '{FSP_FUSE_LOW_RESET, {2'h3, FSP_LOCK_RESET},
    {6'h3F, FSP_FUSE_EXT_RESET}, FSP_FUSE_HIGH_RESET};
  logic [6:0] w;
  logic [15:0] d;
  logic [3:0] lk;
  logic [3:0] m;

  fsp_sequencer #(.PROG_CYCLES(PROG)) dut_u (
    .ref_clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .instr, .eeprom_write_active(ee_act),
    .eeprom_write_start(ee_start), .buf_rd_idx(idx), .buf_rd_data(bufd),
    .lpm_data, .lpm_valid, .flash_op, .region_busy_flag(busy), .cpu_halt(halt),
    .ready_irq(irq)
  );
  fsp_core_model core_u (
    .ref_clk, .srst, .go, .go_lpm, .go_dly, .go_ptr, .go_data, .instr
  );

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    if (failures == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  function automatic logic [15:0] rnd(input int n);
    return 16'($unsigned($random(seed)) % n);
  endfunction : rnd

  function automatic logic [31:0] nxt();
    return exp_q.size() > 0 ? exp_q.pop_front() : 'x;
  endfunction : nxt

  // --------------------------------------------------------------
  // Bus and instruction drivers
  // --------------------------------------------------------------
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h00_0000, v};
    do @(posedge ref_clk);
    while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 8'h00);
  endtask : rd

  task automatic op(input logic [7:0] cmd, input logic l, input logic [2:0] dl,
                    input logic [15:0] p, input logic [15:0] v);
    wb(1'b1, FSP_CTRL_OFS, cmd);
    go <= 1'b1;
    go_lpm <= l;
    go_dly <= dl;
    go_ptr <= p;
    go_data <= v;
    @(posedge ref_clk);
    go <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask : op

  task automatic peek(input logic [6:0] i);
    idx <= i;
    repeat (2) @(posedge ref_clk);
  endtask : peek

  always @(posedge ref_clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      check("bus read", wb_dat_o, nxt());
    end
    if (lpm_valid === 1'b1) begin
      check("readback", 32'(lpm_data), nxt());
    end
    if (flash_op.start === 1'b1 || flash_op.lock === 1'b1) begin
      check("flash op", {20'h0_0000, flash_op}, nxt());
    end
  end

  // The span is several times what the whole sequence needs.
  initial begin
    repeat (4000) @(posedge ref_clk);
    check("watchdog", 32'h1, 32'h0);
    stop_test();
  end

  initial begin
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    rd(FSP_CTRL_OFS, 32'h0000_0000);
    rd(FSP_LOCK_OFS, 32'h0000_00FF);
    rd(8'h0C, 32'h0000_0000);
    foreach (bad[i]) begin
      wb(1'b1, FSP_CTRL_OFS, bad[i]);
      rd(FSP_CTRL_OFS, 32'h0000_0000);
    end
    for (int i = 0; i < 4; i++) begin
      exp_q.push_back(32'(fuse[i]));
      op(8'h09, 1'b1, 3'(rnd(2)), 16'(i), 16'h0000);
      rd(FSP_CTRL_OFS, 32'h0000_0000);
    end
    w = 7'(rnd(128));
    d = rnd(65536);
    op(8'h01, 1'b0, 3'(rnd(3)), {8'h00, w, 1'h1}, d);
    peek(w);
    check("buffer", 32'(bufd), 32'(d));
    exp_q.push_back(32'h0000_0C05);
    op(8'h03, 1'b0, 3'h2, 16'h0500, ~d);
    check("busy", 32'(busy), 32'h1);
    check("halt", 32'(halt), 32'h0);
    rd(FSP_CTRL_OFS, 32'h0000_0043);
    repeat (PROG) @(posedge ref_clk);
    rd(FSP_CTRL_OFS, 32'h0000_0040);
    op(8'h01, 1'b0, 3'(rnd(3)), {8'h00, ~w, 1'h0}, d);
    check("busy", 32'(busy), 32'h0);
    op(8'h11, 1'b0, 3'(rnd(3)), 16'h0000, d);
    peek(~w);
    check("buffer", 32'(bufd), 32'h0000_FFFF);
    op(8'h01, 1'b0, 3'(rnd(3)), {8'h00, w, 1'h0}, d);
    exp_q.push_back(32'h0000_0CE1);
    op(8'h03, 1'b0, 3'h1, 16'hE100, 16'h0000);
    repeat (PROG) @(posedge ref_clk);
    exp_q.push_back(32'h0000_0AE1);
    op(8'h85, 1'b0, 3'(rnd(3)), 16'hE100, 16'h0000);
    check("halt", 32'(halt), 32'h1);
    check("irq", 32'(irq), 32'h0);
    repeat (PROG) @(posedge ref_clk);
    check("halt", 32'(halt), 32'h0);
    check("irq", 32'(irq), 32'h1);
    peek(w);
    check("buffer", 32'(bufd), 32'h0000_FFFF);
    wb(1'b1, FSP_CTRL_OFS, 8'h00);
    peek(w);
    check("irq", 32'(irq), 32'h0);
    lk = 4'hF;
    repeat (2) begin
      m = 4'(rnd(16));
      lk = lk & m;
      exp_q.push_back(32'h0000_0100);
      op(8'h09, 1'b0, 3'(rnd(3)), 16'h0001, {8'hFF, 2'h3, m, 2'h3});
      repeat (PROG) @(posedge ref_clk);
      rd(FSP_LOCK_OFS, {24'h00_0000, 2'h3, lk, 2'h3});
      exp_q.push_back({24'h00_0000, 2'h3, lk, 2'h3});
      op(8'h09, 1'b1, 3'(rnd(2)), 16'h0001, 16'h0000);
    end
    ee_act <= 1'b1;
    op(8'h03, 1'b0, 3'h0, 16'h0600, 16'h0000);
    rd(FSP_CTRL_OFS, 32'h0000_0000);
    check("busy", 32'(busy), 32'h0);
    ee_act <= 1'b0;
    op(8'h01, 1'b0, 3'(rnd(3)), {8'h00, w, 1'h0}, d);
    ee_start <= 1'b1;
    @(posedge ref_clk);
    ee_start <= 1'b0;
    peek(w);
    check("buffer", 32'(bufd), 32'h0000_FFFF);
    op(8'h01, 1'b0, 3'h4, {8'h00, w, 1'h0}, d);
    rd(FSP_CTRL_OFS, 32'h0000_0000);
    peek(w);
    check("buffer", 32'(bufd), 32'h0000_FFFF);
    op(8'h01, 1'b0, 3'(rnd(3)), {8'h00, w, 1'h0}, d);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    peek(w);
    check("buffer", 32'(bufd), 32'h0000_FFFF);
    check("pending", 32'(exp_q.size()), 32'h0);
    stop_test();
  end
endmodule : fsp_sequencer_bench
